/* File: src/flash_prot_pkg.sv */
/*
  Shared constants for the flash write-protection block: instruction codes, address field positions,
  reset values, frame lengths and state encodings.
  Assumes an SPI host that sends MSB-first, one instruction per chip-select frame.
*/
package flash_prot_pkg;

  // Instruction codes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_QUAD_PROG_A = 8'h32;
  localparam logic [7:0] OP_QUAD_PROG_B = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hD7;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
  localparam logic [7:0] OP_FUNC_READ = 8'h48;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_INFO_ROW_PROG = 8'h62;

  // Frame lengths in bits
  localparam logic [5:0] FRAME_OPCODE_BITS = 6'h08;
  localparam logic [5:0] FRAME_BYTE_BITS = 6'h10;
  localparam logic [5:0] FRAME_ADDR_BITS = 6'h20;
  localparam logic [5:0] FRAME_DATA_BITS = 6'h28;
  localparam logic [5:0] FRAME_COUNT_TOP = 6'h3F;
  localparam logic [5:0] FRAME_COUNT_WRAP = 6'h38;

  // Address fields
  localparam int unsigned BLOCK_LSB = 16;
  localparam int unsigned INFO_ROW_LSB = 8;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FUNCTION_RESET = 8'h00;
  localparam logic [15:0] SNAPSHOT_RESET = 16'h0000;

  // Busy durations in clock cycles
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned PROGRAM_CYCLES_DEFAULT = 16;
  localparam int unsigned ERASE_CYCLES_DEFAULT = 64;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_SUSPENDED = 3'h4
  } op_state_t;

  typedef enum logic [3:0] {
    KIND_PROGRAM = 4'h1,
    KIND_ERASE = 4'h2,
    KIND_INFO_ROW = 4'h4,
    KIND_CHIP = 4'h8
  } op_kind_t;

  // Is 64 KB block blk inside the area chosen by the block-protect code?
  function automatic logic block_protected(input logic [3:0] bp, input logic [5:0] blk);
    logic [6:0] span;
    logic hit;
    span = 7'h00;
    hit = 1'b0;
    if (bp >= 4'h1 && bp <= 4'h6)
    begin
      span = 7'h01 << (bp - 4'h1);
      hit = ({1'b0, blk} >= (7'h40 - span));
    end
    else if (bp == 4'h7 || bp == 4'h8)
    begin
      hit = 1'b1;
    end
    else if (bp >= 4'h9 && bp <= 4'hE)
    begin
      span = 7'h20 >> (bp - 4'h9);
      hit = ({1'b0, blk} < span);
    end
    return hit;
  endfunction

endpackage

/* File: src/spi_capture_if.sv */
/*
  Carrier between the serial-clock capture logic and the system-clock core.
  Capture words are only read by the core after the frame has ended.
*/
`timescale 1ns/1ns
interface spi_capture_if;
  logic [7:0] opcode;
  logic [31:0] body;
  logic [5:0] bit_count;
  logic frame_toggle;
  logic [15:0] snapshot;

  modport capture
  (
    output opcode,
    output body,
    output bit_count,
    output frame_toggle,
    input snapshot
  );

  modport core
  (
    input opcode,
    input body,
    input bit_count,
    input frame_toggle,
    output snapshot
  );
endinterface

/* File: src/spi_capture.sv */
/*
  Serial-clock side: shifts in opcode and body bits, toggles once per frame,
  and shifts register contents out for the two read instructions.
  Assumes the serial clock idles between frames (modes 0 and 3).
*/
`timescale 1ns/1ns
module spi_capture
(
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  spi_capture_if.capture link
);
  logic in_frame_reg;
  logic [5:0] count_reg;
  logic [5:0] count_next;
  logic [7:0] opcode_reg;
  logic [31:0] body_reg;
  // No reset reaches this domain; starts at the core tracker's reset value of zero
  logic toggle_reg = 1'b0;
  logic is_read;

  // Count keeps its value after the frame so the core can read it
  assign count_next = !in_frame_reg ? 6'h01 :
                      (count_reg == flash_prot_pkg::FRAME_COUNT_TOP) ?
                      flash_prot_pkg::FRAME_COUNT_WRAP : count_reg + 6'h01;

  always_ff @(posedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      in_frame_reg <= 1'b0;
    else
      in_frame_reg <= 1'b1;
  end

  always_ff @(posedge spi_sck)
  begin
    count_reg <= count_next;
    if (!in_frame_reg)
      toggle_reg <= ~toggle_reg;
    if (count_next <= flash_prot_pkg::FRAME_OPCODE_BITS)
      opcode_reg <= {opcode_reg[6:0], spi_si};
    else if (count_next <= flash_prot_pkg::FRAME_DATA_BITS)
      body_reg <= {body_reg[30:0], spi_si};
  end

  // RULE_15: read opcodes
  assign is_read = (opcode_reg == flash_prot_pkg::OP_STATUS_READ) ||
                   (opcode_reg == flash_prot_pkg::OP_FUNC_READ);

  // Data leaves on the falling edge; the register repeats every eight clocks
  always_ff @(negedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end
    else if (is_read && count_reg >= flash_prot_pkg::FRAME_OPCODE_BITS)
    begin
      spi_so_oe <= 1'b1;
      if (opcode_reg == flash_prot_pkg::OP_STATUS_READ)
        spi_so <= link.snapshot[{1'b1, ~count_reg[2:0]}];
      else
        spi_so <= link.snapshot[{1'b0, ~count_reg[2:0]}];
    end
  end

  assign link.opcode = opcode_reg;
  assign link.body = body_reg;
  assign link.bit_count = count_reg;
  assign link.frame_toggle = toggle_reg;
endmodule

/* File: src/flash_protect_unit.sv */
/*
  Write-protection, write-enable, suspend and function-register logic of a
  serial flash, executing each instruction when its chip-select frame ends.
  Assumes the array itself sits outside and only needs start requests.
*/
// Contract
// RULE_01: Block-protect code selects top or bottom 64 KB block ranges, all or none.
// RULE_02: Suspend during a program sets the program-suspended flag, bit 2.
// RULE_03: Resuming the program clears the program-suspended flag.
// RULE_04: Suspend during an erase sets the erase-suspended flag, bit 3.
// RULE_05: Resuming the erase clears the erase-suspended flag.
// RULE_06: Four row lock bits in bits 4 to 7 block info-row programs.
// RULE_07: Lock bits are one-time programmable; never return to zero. The code clears them to FUNCTION_RESET[7:4], zero, on reset.
// RULE_08: Status writes blocked only with disable bit set and protect pin low.
// RULE_09: Pin gating covers block-protect, quad-enable and write-disable bits.
// RULE_10: Program, erase and register writes ignored while write-enable latch clear.
// RULE_11: Host sends write-enable before every program, erase or register write.
// RULE_12: Program or erase into a protected block is inhibited.
// RULE_13: Chip erase ignored unless all block-protect bits are zero.
// RULE_14: Write-enable latch clears when any write, program or erase completes.
// RULE_15: Function register read with code 48h, written with code 42h.
// RULE_16: Function writes leave bits 0 to 3 alone; reserved bits read zero.
`timescale 1ns/1ns
module flash_protect_unit #(
  parameter int unsigned PROGRAM_CYCLES = flash_prot_pkg::PROGRAM_CYCLES_DEFAULT,
  parameter int unsigned ERASE_CYCLES = flash_prot_pkg::ERASE_CYCLES_DEFAULT
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic write_protect_n,
  output logic [7:0] status_value,
  output logic [7:0] function_value,
  output logic array_op_start,
  output flash_prot_pkg::op_kind_t array_op_kind,
  output logic [23:0] array_op_addr
);
  spi_capture_if link ();

  spi_capture capture_unit
  (
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_si(spi_si),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .link(link.capture)
  );

  logic cs_sync1_reg, cs_sync2_reg, cs_prev_reg;
  logic wp_sync1_reg, wp_sync2_reg;
  logic tog_sync1_reg, tog_sync2_reg, tog_done_reg;
  logic write_enable_latch_reg;
  logic [3:0] block_protect_reg;
  logic quad_enable_bit_reg;
  logic status_write_disable_reg;
  logic [3:0] info_row_lock_reg;
  logic program_suspended_flag_reg;
  logic erase_suspended_flag_reg;
  flash_prot_pkg::op_state_t state_reg;
  flash_prot_pkg::op_kind_t kind_reg;
  logic [flash_prot_pkg::TIMER_W-1:0] timer_reg;
  logic [15:0] snapshot_reg;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cs_sync1_reg <= 1'b1;
      cs_sync2_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      wp_sync1_reg <= 1'b1;
      wp_sync2_reg <= 1'b1;
      tog_sync1_reg <= 1'b0;
      tog_sync2_reg <= 1'b0;
      tog_done_reg <= 1'b0;
    end
    else
    begin
      cs_sync1_reg <= spi_cs_n;
      cs_sync2_reg <= cs_sync1_reg;
      cs_prev_reg <= cs_sync2_reg;
      wp_sync1_reg <= write_protect_n;
      wp_sync2_reg <= wp_sync1_reg;
      tog_sync1_reg <= link.frame_toggle;
      tog_sync2_reg <= tog_sync1_reg;
      if (cs_sync2_reg)
        tog_done_reg <= tog_sync2_reg;
    end
  end

  // A frame counts only if its toggle moved, so an empty select pulse does nothing
  logic frame_end;
  assign frame_end = cs_sync2_reg && !cs_prev_reg && (tog_sync2_reg != tog_done_reg);

  logic [7:0] op;
  logic [5:0] bits;
  assign op = link.opcode;
  assign bits = link.bit_count;

  logic is_set_write_enable_instr, is_wrdi, is_swrite, is_fwrite, is_prog, is_erase;
  logic is_chip, is_irp, is_susp, is_rsm;
  assign is_set_write_enable_instr = (op == flash_prot_pkg::OP_WRITE_ENABLE);
  assign is_wrdi = (op == flash_prot_pkg::OP_WRITE_DISABLE);
  assign is_swrite = (op == flash_prot_pkg::OP_STATUS_WRITE) &&
                     (bits == flash_prot_pkg::FRAME_BYTE_BITS);
  // RULE_15: function write code
  assign is_fwrite = (op == flash_prot_pkg::OP_FUNC_WRITE) &&
                     (bits == flash_prot_pkg::FRAME_BYTE_BITS);
  assign is_prog = (op == flash_prot_pkg::OP_PAGE_PROG || op == flash_prot_pkg::OP_QUAD_PROG_A ||
                    op == flash_prot_pkg::OP_QUAD_PROG_B) &&
                   (bits >= flash_prot_pkg::FRAME_DATA_BITS);
  assign is_erase = (op == flash_prot_pkg::OP_SECTOR_ERASE_A ||
                     op == flash_prot_pkg::OP_SECTOR_ERASE_B ||
                     op == flash_prot_pkg::OP_BLOCK32_ERASE ||
                     op == flash_prot_pkg::OP_BLOCK64_ERASE) &&
                    (bits == flash_prot_pkg::FRAME_ADDR_BITS);
  assign is_chip = (op == flash_prot_pkg::OP_CHIP_ERASE_A || op == flash_prot_pkg::OP_CHIP_ERASE_B);
  assign is_irp = (op == flash_prot_pkg::OP_INFO_ROW_PROG) &&
                  (bits >= flash_prot_pkg::FRAME_DATA_BITS);
  assign is_susp = (op == flash_prot_pkg::OP_SUSPEND_A || op == flash_prot_pkg::OP_SUSPEND_B);
  assign is_rsm = (op == flash_prot_pkg::OP_RESUME_A || op == flash_prot_pkg::OP_RESUME_B);

  logic [23:0] target;
  logic [5:0] target_block;
  logic [1:0] target_row;
  assign target = (is_prog || is_irp) ? link.body[31:8] : link.body[23:0];
  assign target_block = target[flash_prot_pkg::BLOCK_LSB +: 6];
  assign target_row = target[flash_prot_pkg::INFO_ROW_LSB +: 2];

  // RULE_10: nothing that writes starts without the latch, nor while an op is pending
  logic write_ok;
  assign write_ok = write_enable_latch_reg && (state_reg == flash_prot_pkg::ST_IDLE);

  // RULE_01: protected-range decode of the current code
  logic target_protected;
  assign target_protected = flash_prot_pkg::block_protected(block_protect_reg, target_block);

  logic start_prog, start_erase, start_chip, start_irp, start_any;
  // RULE_12: inhibit array ops inside the protected area
  assign start_prog = frame_end && write_ok && is_prog && !target_protected;
  assign start_erase = frame_end && write_ok && is_erase && !target_protected;
  // RULE_13: chip erase needs all protect bits clear
  assign start_chip = frame_end && write_ok && is_chip && (block_protect_reg == 4'h0);
  // RULE_06: locked rows refuse programming
  assign start_irp = frame_end && write_ok && is_irp && !info_row_lock_reg[target_row];
  assign start_any = start_prog || start_erase || start_chip || start_irp;

  // RULE_08: pin and disable bit together lock the status register
  logic status_locked;
  assign status_locked = status_write_disable_reg && !wp_sync2_reg;

  logic do_swrite, do_fwrite, op_done;
  assign do_swrite = frame_end && write_ok && is_swrite && !status_locked;
  assign do_fwrite = frame_end && write_ok && is_fwrite;
  assign op_done = (state_reg == flash_prot_pkg::ST_RUN) &&
                   (timer_reg == flash_prot_pkg::TIMER_W'(1));

  // RULE_14: completion clears the latch; a same-cycle enable wins
  always_ff @(posedge clock)
  begin
    if (!resetn)
      write_enable_latch_reg <= flash_prot_pkg::STATUS_RESET[1];
    else if (frame_end && is_set_write_enable_instr)
      write_enable_latch_reg <= 1'b1;
    else if (op_done || do_swrite || do_fwrite || (frame_end && is_wrdi))
      write_enable_latch_reg <= 1'b0;
  end

  // RULE_09: gated status fields
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      block_protect_reg <= flash_prot_pkg::STATUS_RESET[5:2];
      quad_enable_bit_reg <= flash_prot_pkg::STATUS_RESET[6];
      status_write_disable_reg <= flash_prot_pkg::STATUS_RESET[7];
    end
    else if (do_swrite)
    begin
      block_protect_reg <= link.body[5:2];
      quad_enable_bit_reg <= link.body[6];
      status_write_disable_reg <= link.body[7];
    end
  end

  // RULE_07: lock bits only accumulate ones
  always_ff @(posedge clock)
  begin
    if (!resetn)
      info_row_lock_reg <= flash_prot_pkg::FUNCTION_RESET[7:4];
    else if (do_fwrite)
      info_row_lock_reg <= info_row_lock_reg | link.body[7:4];
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_reg <= flash_prot_pkg::ST_IDLE;
      kind_reg <= flash_prot_pkg::KIND_PROGRAM;
      timer_reg <= '0;
    end
    else
    begin
      case (state_reg)
        flash_prot_pkg::ST_IDLE:
        begin
          if (start_any)
          begin
            state_reg <= flash_prot_pkg::ST_RUN;
            if (start_prog || start_irp)
              timer_reg <= flash_prot_pkg::TIMER_W'(PROGRAM_CYCLES);
            else
              timer_reg <= flash_prot_pkg::TIMER_W'(ERASE_CYCLES);
            kind_reg <= start_prog ? flash_prot_pkg::KIND_PROGRAM :
                        start_irp ? flash_prot_pkg::KIND_INFO_ROW :
                        start_chip ? flash_prot_pkg::KIND_CHIP : flash_prot_pkg::KIND_ERASE;
          end
        end
        flash_prot_pkg::ST_RUN:
        begin
          if (op_done)
            state_reg <= flash_prot_pkg::ST_IDLE;
          else if (frame_end && is_susp)
            state_reg <= flash_prot_pkg::ST_SUSPENDED;
          timer_reg <= timer_reg - flash_prot_pkg::TIMER_W'(1);
        end
        flash_prot_pkg::ST_SUSPENDED:
        begin
          if (frame_end && is_rsm)
            state_reg <= flash_prot_pkg::ST_RUN;
        end
        default:
          state_reg <= flash_prot_pkg::ST_IDLE;
      endcase
    end
  end

  logic suspend_now, resume_now, prog_kind;
  assign suspend_now = frame_end && is_susp && (state_reg == flash_prot_pkg::ST_RUN) && !op_done;
  assign resume_now = frame_end && is_rsm && (state_reg == flash_prot_pkg::ST_SUSPENDED);
  assign prog_kind = (kind_reg == flash_prot_pkg::KIND_PROGRAM) ||
                     (kind_reg == flash_prot_pkg::KIND_INFO_ROW);

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      program_suspended_flag_reg <= flash_prot_pkg::FUNCTION_RESET[2];
      erase_suspended_flag_reg <= flash_prot_pkg::FUNCTION_RESET[3];
    end
    else
    begin
      // RULE_02: program suspended
      if (suspend_now && prog_kind)
        program_suspended_flag_reg <= 1'b1;
      // RULE_03: program resumed
      else if (resume_now)
        program_suspended_flag_reg <= 1'b0;
      // RULE_04: erase suspended
      if (suspend_now && !prog_kind)
        erase_suspended_flag_reg <= 1'b1;
      // RULE_05: erase resumed
      else if (resume_now)
        erase_suspended_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      array_op_start <= 1'b0;
      array_op_kind <= flash_prot_pkg::KIND_PROGRAM;
      array_op_addr <= 24'h000000;
    end
    else
    begin
      array_op_start <= start_any;
      if (start_any)
      begin
        array_op_kind <= start_prog ? flash_prot_pkg::KIND_PROGRAM :
                         start_irp ? flash_prot_pkg::KIND_INFO_ROW :
                         start_chip ? flash_prot_pkg::KIND_CHIP : flash_prot_pkg::KIND_ERASE;
        array_op_addr <= start_chip ? 24'h000000 : target;
      end
    end
  end

  // RULE_16: bits 0 and 1 are constant zero, bits 2 and 3 follow the suspend flags only
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      status_value <= flash_prot_pkg::STATUS_RESET;
      function_value <= flash_prot_pkg::FUNCTION_RESET;
    end
    else
    begin
      status_value <= {status_write_disable_reg, quad_enable_bit_reg, block_protect_reg,
                       write_enable_latch_reg, state_reg == flash_prot_pkg::ST_RUN};
      function_value <= {info_row_lock_reg, erase_suspended_flag_reg,
                         program_suspended_flag_reg, 2'b00};
    end
  end

  // Frozen while select is low; the first eight clocks cover the sync delay
  always_ff @(posedge clock)
  begin
    if (!resetn)
      snapshot_reg <= flash_prot_pkg::SNAPSHOT_RESET;
    else if (cs_sync2_reg)
      snapshot_reg <= {status_value, function_value};
  end
  assign link.snapshot = snapshot_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_full_range_code: assert property ( // RULE_01
    (block_protect_reg == 4'h7 || block_protect_reg == 4'h8) |->
    (flash_prot_pkg::block_protected(block_protect_reg, 6'h00) &&
     flash_prot_pkg::block_protected(block_protect_reg, 6'h3F)))
    else $error("full-range code leaves a block open");
  a_prog_suspend_set: assert property ( // RULE_02
    suspend_now && prog_kind |=> program_suspended_flag_reg ##1 function_value[2])
    else $error("program suspend flag not set");
  a_prog_resume_clear: assert property ( // RULE_03
    resume_now |=> !program_suspended_flag_reg && state_reg == flash_prot_pkg::ST_RUN)
    else $error("program suspend flag not cleared on resume");
  a_erase_suspend_set: assert property ( // RULE_04
    suspend_now && !prog_kind |=> erase_suspended_flag_reg ##1 function_value[3])
    else $error("erase suspend flag not set");
  a_erase_resume_clear: assert property ( // RULE_05
    resume_now |=> !erase_suspended_flag_reg)
    else $error("erase suspend flag not cleared on resume");
  a_locked_row_refused: assert property ( // RULE_06
    array_op_start && array_op_kind == flash_prot_pkg::KIND_INFO_ROW |->
    !info_row_lock_reg[array_op_addr[flash_prot_pkg::INFO_ROW_LSB +: 2]])
    else $error("locked information row programmed");
  a_lock_otp_hold: assert property ( // RULE_07
    ($past(info_row_lock_reg) & ~info_row_lock_reg) == 4'h0)
    else $error("lock bit returned to zero");
  a_status_pin_lock: assert property ( // RULE_08
    frame_end && is_swrite && status_write_disable_reg && !wp_sync2_reg |=>
    $stable(block_protect_reg) && $stable(status_write_disable_reg) && $stable(quad_enable_bit_reg))
    else $error("status written while hardware protected");
  a_no_latch_no_write: assert property ( // RULE_10
    frame_end && !write_enable_latch_reg |=> !array_op_start && $stable(info_row_lock_reg))
    else $error("write accepted without latch");
  a_protected_inhibit: assert property ( // RULE_12
    array_op_start && (array_op_kind == flash_prot_pkg::KIND_PROGRAM ||
    array_op_kind == flash_prot_pkg::KIND_ERASE) |->
    !flash_prot_pkg::block_protected($past(block_protect_reg), array_op_addr[21:16]))
    else $error("protected block targeted");
  a_chip_erase_guard: assert property ( // RULE_13
    array_op_start && array_op_kind == flash_prot_pkg::KIND_CHIP |-> $past(block_protect_reg) == 4'h0)
    else $error("chip erase with protect bits set");
  a_done_clears_latch: assert property ( // RULE_14
    op_done && !(frame_end && is_set_write_enable_instr) |=> !write_enable_latch_reg ##1 status_value[1:0] == 2'b00)
    else $error("latch survives completion");
  a_func_low_bits: assert property ( // RULE_16
    do_fwrite |=> $stable(program_suspended_flag_reg) && $stable(erase_suspended_flag_reg)
    ##1 function_value[1:0] == 2'b00)
    else $error("function write touched low bits");

  c_program_start: cover property (array_op_start && array_op_kind == flash_prot_pkg::KIND_PROGRAM);
  c_suspend_resume: cover property (suspend_now ##[1:1000] resume_now);
  c_status_locked: cover property (frame_end && is_swrite && status_locked);
  c_lock_set: cover property (do_fwrite && link.body[7:4] != 4'h0);
endmodule

/* File: tb/spi_host_model.sv */
/*
  SPI host model: one instruction per chip-select frame, mode 0, MSB first.
  Assumes the device sends read data on the falling serial clock edge.
*/
`timescale 1ns/1ns
module spi_host_model
(
  output logic spi_sck = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_si = 1'b0,
  input wire logic spi_so
);
  task automatic frame(input logic [39:0] b, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #13;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_si = b[39 - i];
      #80;
      spi_sck = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], spi_so};
      #80;
      spi_sck = 1'b0;
    end
    #80;
    spi_cs_n = 1'b1;
    // Idle data line flips so a stale bit is never mistaken for data
    spi_si = ~spi_si;
    #700;
  endtask
endmodule

/* File: tb/flash_protect_unit_tb.sv */
/*
  Self-checking bench for the flash protection unit.
  Assumes busy counts of 40 and 80 cycles, long enough that suspend frames land inside an operation.
*/
`timescale 1ns/1ns
module flash_protect_unit_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic write_protect_n = 1'b1;
  logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, array_op_start;
  logic [7:0] status_value, function_value, rd;
  flash_prot_pkg::op_kind_t array_op_kind;
  logic [23:0] array_op_addr;
  int n_errors = 0;
  int total_checks = 0;
  int n_starts = 0;
  int ns;
  int blks[6] = '{0, 1, 31, 32, 62, 63};
  always #50 clock = ~clock;
  always @(posedge clock)
    if (array_op_start === 1'b1)
      n_starts <= n_starts + 1;
  flash_protect_unit #(.PROGRAM_CYCLES(40), .ERASE_CYCLES(80)) flash_protect_unit_inst
  (
    .clock, .resetn, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe, .write_protect_n,
    .status_value, .function_value, .array_op_start, .array_op_kind, .array_op_addr
  );
  spi_host_model spi_host_model_inst (.spi_sck, .spi_cs_n, .spi_si, .spi_so);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [39:0] b, input int n);
    spi_host_model_inst.frame(b, n, rd);
  endtask
  task automatic wsend(input logic [39:0] b, input int n);
    send({flash_prot_pkg::OP_WRITE_ENABLE, 32'h0}, 8);
    send(b, n);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 300 && status_value[0] !== 1'b0; i++)
      @(negedge clock);
    check(status_value[0], 1'b0);
  endtask
  task automatic wp(input logic v);
    @(posedge clock);
    write_protect_n <= v;
    repeat (3) @(posedge clock);
  endtask
  task automatic sw(input logic [7:0] d);
    wsend({flash_prot_pkg::OP_STATUS_WRITE, d, 24'h0}, 16);
  endtask
  function automatic logic prot(input int c, input int b);
    if (c >= 1 && c <= 6)
      return b >= 64 - (1 << (c - 1));
    if (c == 7 || c == 8)
      return 1'b1;
    if (c >= 9 && c <= 14)
      return b < (32 >> (c - 9));
    return 1'b0;
  endfunction
  task automatic t_func;
    check(function_value, 8'h00);
    send({flash_prot_pkg::OP_WRITE_ENABLE, 32'h0}, 8);
    check(status_value[1], 1'b1);
    send({flash_prot_pkg::OP_WRITE_DISABLE, 32'h0}, 8);
    check(status_value[1], 1'b0);
    send({flash_prot_pkg::OP_FUNC_WRITE, 8'hFF, 24'h0}, 16);
    check(function_value, 8'h00);
    wsend({flash_prot_pkg::OP_FUNC_WRITE, 8'h1F, 24'h0}, 16);
    check(function_value, 8'h10);
    check(status_value[1], 1'b0);
    wsend({flash_prot_pkg::OP_FUNC_WRITE, 8'h20, 24'h0}, 16);
    check(function_value, 8'h30);
    send({flash_prot_pkg::OP_FUNC_READ, 32'h0}, 16);
    check(rd, 8'h30);
    check(spi_so_oe, 1'b0);
    ns = n_starts;
    wsend({flash_prot_pkg::OP_INFO_ROW_PROG, 24'h000100, 8'hA5}, 40);
    check(n_starts - ns, 0);
    wsend({flash_prot_pkg::OP_INFO_ROW_PROG, 24'h000200, 8'hA5}, 40);
    check(n_starts - ns, 1);
    check(array_op_kind, flash_prot_pkg::KIND_INFO_ROW);
    check(array_op_addr, 24'h000200);
    wait_idle();
  endtask
  task automatic t_status;
    sw(8'h84);
    check(status_value, 8'h84);
    wp(1'b0);
    sw(8'h40);
    check(status_value, 8'h86);
    wp(1'b1);
    sw(8'h00);
    check(status_value, 8'h00);
    wp(1'b0);
    sw(8'h48);
    check(status_value, 8'h48);
    send({flash_prot_pkg::OP_STATUS_READ, 32'h0}, 16);
    check(rd, 8'h48);
    wp(1'b1);
  endtask
  task automatic t_codes;
    for (int c = 0; c < 16; c++)
    begin
      sw({2'b00, 4'(c), 2'b00});
      foreach (blks[k])
      begin
        ns = n_starts;
        wsend({flash_prot_pkg::OP_BLOCK64_ERASE, 2'b00, 6'(blks[k]), 24'h0}, 32);
        check(n_starts - ns, !prot(c, blks[k]));
        wait_idle();
      end
      ns = n_starts;
      wsend({flash_prot_pkg::OP_CHIP_ERASE_A, 32'h0}, 8);
      check(n_starts - ns, c == 0);
      wait_idle();
    end
    sw(8'h00);
  endtask
  task automatic t_susp(input logic [7:0] op, input logic [7:0] su, input logic [7:0] re,
      input logic [1:0] f, input int n);
    wsend({op, 24'h000100, 8'h5A}, n);
    send({su, 32'h0}, 8);
    check(function_value[3:2], f);
    send({re, 32'h0}, 8);
    check(function_value[3:2], 2'b00);
    wait_idle();
    check(status_value[1:0], 2'b00);
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_func();
    t_status();
    t_codes();
    t_susp(flash_prot_pkg::OP_PAGE_PROG, flash_prot_pkg::OP_SUSPEND_A,
        flash_prot_pkg::OP_RESUME_A, 2'b01, 40);
    t_susp(flash_prot_pkg::OP_SECTOR_ERASE_A, flash_prot_pkg::OP_SUSPEND_B,
        flash_prot_pkg::OP_RESUME_B, 2'b10, 32);
    tally_and_finish();
  end
  initial
  begin
    #5000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
